/* File: common/fault_cfg.svh */
// Offsets, field positions and reset values of the fault aggregation block.
// Included by the design and the testbench; definitions only.
`ifndef FAULT_CFG_SVH
`define FAULT_CFG_SVH

// Register byte offsets (one 32-bit word each)
`define OFS_MASK1 8'h00
`define OFS_MASK2 8'h04
`define OFS_CLR1 8'h08
`define OFS_CLR2 8'h0c
`define OFS_CFG 8'h10
`define OFS_SUMMARY 8'h14
`define OFS_FLAG0 8'h18
`define OFS_DETAIL0 8'h48
`define NUM_FLAG_REGS 12
`define NUM_DETAIL_REGS 10

// Reset values
`define RST_MASK1 8'h00
`define RST_MASK2 8'h00
`define RST_CFG 8'h00

// First mask/clear register bits
`define M1_PWR 0
`define M1_SYS 1
`define M1_COMP 2
`define M1_OV 3
`define M1_UV 4
`define M1_OT 5
`define M1_UT 6
`define M1_PROT 7
// Second mask/clear register bits
`define M2_COMM1 0
`define M2_COMM2 1
`define M2_HB 2
`define M2_TONE 3
`define M2_CHAIN 4
`define M2_NVM_DATA 5
`define M2_NVM_CRC 6

// Summary bits
`define S_PWR 0
`define S_SYS 1
`define S_OVUV 2
`define S_OTUT 3
`define S_COMM 4
`define S_NVM 5
`define S_COMP 6
`define S_PROT 7

// Device configuration bits
`define CFG_PIN_EN 0
`define CFG_EMBED_EN 1
`define CFG_BASE 2

// Flag register indices
`define F_PROT 0
`define F_UT 1
`define F_OT 2
`define F_UV 3
`define F_OV 4
`define F_COMP 5
`define F_SYS 6
`define F_PWR 7
`define F_NVM 8
`define F_HOST 9
`define F_CHAIN 10
`define F_TONE 11
// Bit of chain_tone_alarm_flags set by a received chain vote
`define B_CHAIN_DET 0
// Detail registers that hold a block location rather than sticky bits
`define D_NVM_SEC 8
`define D_NVM_DED 9

`endif

/* File: common/fault_pkg.sv */
// Types of the fault aggregation block.
// Bank widths are written out here and match NUM_FLAG_REGS and NUM_DETAIL_REGS of fault_cfg.svh.
package fault_pkg;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WR = 3'b010,
		BUS_RD = 3'b100
	} bus_phase_t;

	// Three status bits carried in a forwarded response frame header
	typedef struct packed {
		logic valid;
		logic [2:0] status;
	} frame_t;

	typedef logic [11:0][7:0] flag_bank_t;
	typedef logic [9:0][7:0] detail_bank_t;

	typedef struct packed {
		bus_phase_t phase;
		logic [7:0] addr;
		logic [7:0] mask1;
		logic [7:0] mask2;
		logic [7:0] cfg;
		logic [7:0] summary;
		flag_bank_t flags;
		detail_bank_t detail;
		logic vote;
		logic [31:0] rdata;
		logic ready;
		logic alarm_n;
		frame_t resp;
	} state_t;

endpackage

/* File: logic/fault_mask_clear_signaling.sv */
// Fault flag latching, group masking/clearing, summary and chain alarm signalling.
// Assumes an AHB-Lite master on hclk; fault inputs and frame strobes are on hclk.
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fault_cfg.svh"

module fault_mask_clear_signaling (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire fault_pkg::flag_bank_t fault_set,
	input wire fault_pkg::flag_bank_t fault_active,
	input wire logic [9:0] detail_load,
	input wire fault_pkg::detail_bank_t detail_value,
	input wire fault_pkg::frame_t resp_in,
	output fault_pkg::frame_t resp_out,
	output logic alarm_out_n
);

	fault_pkg::state_t st;
	fault_pkg::state_t nx;
	logic [7:0] clr1;
	logic [7:0] clr2;
	logic cfg_wr;
	logic vote_now;
	fault_pkg::flag_bank_t cvec;
	logic [9:0] dclr;
	logic hresp_reg;

	// One layout for mask and clear bits
	function automatic fault_pkg::flag_bank_t group_vec(input logic [7:0] r1,
		input logic [7:0] r2);
		fault_pkg::flag_bank_t v;
		v = '0;
		v[`F_PROT] = {8{r1[`M1_PROT]}};
		v[`F_UT] = {8{r1[`M1_UT]}};
		v[`F_OT] = {8{r1[`M1_OT]}};
		v[`F_UV] = {8{r1[`M1_UV]}};
		v[`F_OV] = {8{r1[`M1_OV]}};
		v[`F_COMP] = {8{r1[`M1_COMP]}};
		v[`F_SYS] = {8{r1[`M1_SYS]}};
		v[`F_PWR] = {8{r1[`M1_PWR]}};
		v[`F_NVM] = {{6{r2[`M2_NVM_DATA]}}, {2{r2[`M2_NVM_CRC]}}};
		v[`F_HOST] = {8{r2[`M2_COMM1]}};
		v[`F_CHAIN] = {8{r2[`M2_COMM2]}};
		v[`F_TONE] = {4'h0, r2[`M2_HB], r2[`M2_HB], r2[`M2_TONE], r2[`M2_CHAIN]};
		return v;
	endfunction

	// Detail registers follow the group of their parent flag register
	function automatic logic [9:0] detail_vec(input logic [7:0] r2);
		return {{2{r2[`M2_NVM_DATA]}}, {6{r2[`M2_COMM2]}}, {2{r2[`M2_COMM1]}}};
	endfunction

	// Summary bit fed by each flag register
	function automatic logic [2:0] sum_bit(input int i);
		case (i)
			`F_PROT: return 3'(`S_PROT);
			`F_UT, `F_OT: return 3'(`S_OTUT);
			`F_UV, `F_OV: return 3'(`S_OVUV);
			`F_COMP: return 3'(`S_COMP);
			`F_SYS: return 3'(`S_SYS);
			`F_PWR: return 3'(`S_PWR);
			`F_NVM: return 3'(`S_NVM);
			default: return 3'(`S_COMM);
		endcase
	endfunction

	// Write strobes decoded in the data phase
	always_comb begin
		clr1 = 8'h00;
		clr2 = 8'h00;
		cfg_wr = 1'b0;
		if (st.phase == fault_pkg::BUS_WR) begin
			if (st.addr == `OFS_CLR1) begin
				clr1 = hwdata[7:0];
			end
			if (st.addr == `OFS_CLR2) begin
				clr2 = hwdata[7:0];
			end
			cfg_wr = (st.addr == `OFS_CFG);
		end
	end

	assign cvec = group_vec(clr1, clr2);
	assign dclr = detail_vec(clr2);
	assign vote_now = st.cfg[`CFG_EMBED_EN] && resp_in.valid &&
		((resp_in.status[0] && resp_in.status[1]) || (resp_in.status[0] && resp_in.status[2]) ||
		(resp_in.status[1] && resp_in.status[2]));

	always_comb begin
		logic [7:0] ra;
		logic [7:0] fi;
		logic [7:0] di;
		fault_pkg::flag_bank_t mn;
		logic [9:0] dm;
		nx = st;
		ra = 8'h00;
		fi = 8'h00;
		di = 8'h00;
		mn = '0;
		dm = '0;
		// Data phase of a write
		if (st.phase == fault_pkg::BUS_WR) begin
			case (st.addr)
				`OFS_MASK1: nx.mask1 = hwdata[7:0];
				`OFS_MASK2: nx.mask2 = hwdata[7:0];
				`OFS_CFG: nx.cfg = hwdata[7:0];
				default: nx.cfg = st.cfg;
			endcase
			nx.phase = fault_pkg::BUS_IDLE;
		end
		// Read data produced one cycle after the address phase
		if (st.phase == fault_pkg::BUS_RD) begin
			ra = st.addr;
			fi = 8'(ra - `OFS_FLAG0) >> 2;
			di = 8'(ra - `OFS_DETAIL0) >> 2;
			nx.rdata = 32'h0000_0000;
			if (ra == `OFS_MASK1) begin
				nx.rdata[7:0] = st.mask1;
			end else if (ra == `OFS_MASK2) begin
				nx.rdata[7:0] = st.mask2;
			end else if (ra == `OFS_CFG) begin
				nx.rdata[7:0] = st.cfg;
			end else if (ra == `OFS_SUMMARY) begin
				nx.rdata[7:0] = st.summary;
			end else if (ra >= `OFS_FLAG0 && fi < 8'(`NUM_FLAG_REGS)) begin
				nx.rdata[7:0] = st.flags[fi[3:0]];
			end else if (ra >= `OFS_DETAIL0 && di < 8'(`NUM_DETAIL_REGS)) begin
				nx.rdata[7:0] = st.detail[di[3:0]];
			end
			nx.ready = 1'b1;
			nx.phase = fault_pkg::BUS_IDLE;
		end
		// Address phase; reads insert one wait state so earlier writes are seen
		if (st.ready && hready && hsel && htrans[1]) begin
			nx.addr = {haddr[7:2], 2'b00};
			if (hwrite) begin
				nx.phase = fault_pkg::BUS_WR;
			end else begin
				nx.phase = fault_pkg::BUS_RD;
				nx.ready = 1'b0;
			end
		end
		// Sticky flags: set and live condition win over clear
		for (int i = 0; i < `NUM_FLAG_REGS; i++) begin
			nx.flags[i] = (st.flags[i] & ~cvec[i]) | fault_set[i];
			nx.flags[i] = nx.flags[i] | (st.flags[i] & fault_active[i]);
		end
		if (vote_now) begin
			nx.flags[`F_TONE][`B_CHAIN_DET] = 1'b1;
		end
		// Unused upper bits of the tone register never latch
		nx.flags[`F_TONE][7:4] = 4'h0;
		for (int j = 0; j < `NUM_DETAIL_REGS; j++) begin
			if (dclr[j]) begin
				nx.detail[j] = 8'h00;
			end
			if (detail_load[j]) begin
				if (j == `D_NVM_SEC || j == `D_NVM_DED) begin
					nx.detail[j] = detail_value[j];
				end else begin
					nx.detail[j] = (dclr[j] ? 8'h00 : st.detail[j]) | detail_value[j];
				end
			end
		end
		// Summary: OR of unmasked flags per group, masks as written this cycle
		mn = group_vec(nx.mask1, nx.mask2);
		dm = detail_vec(nx.mask2);
		nx.summary = 8'h00;
		for (int i = 0; i < `NUM_FLAG_REGS; i++) begin
			if (|(nx.flags[i] & ~mn[i])) begin
				nx.summary[sum_bit(i)] = 1'b1;
			end
		end
		for (int j = 0; j < `NUM_DETAIL_REGS; j++) begin
			if ((nx.detail[j] != 8'h00) && !dm[j]) begin
				if (j == `D_NVM_SEC || j == `D_NVM_DED) begin
					nx.summary[`S_NVM] = 1'b1;
				end else begin
					nx.summary[`S_COMM] = 1'b1;
				end
			end
		end
		// Base keeps the vote of the latest received frame
		if (resp_in.valid) begin
			nx.vote = vote_now;
		end
		// Forwarded frame carries this device's fault state
		nx.resp.valid = resp_in.valid;
		nx.resp.status = resp_in.status;
		if (st.cfg[`CFG_EMBED_EN]) begin
			nx.resp.status = resp_in.status | {3{|st.summary}};
		end
		nx.alarm_n = !(nx.cfg[`CFG_PIN_EN] &&
			(|nx.summary || (nx.cfg[`CFG_BASE] && nx.vote)));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '{phase: fault_pkg::BUS_IDLE, addr: 8'h00, mask1: `RST_MASK1,
				mask2: `RST_MASK2, cfg: `RST_CFG, summary: 8'h00, flags: '0,
				detail: '0, vote: 1'b0, rdata: 32'h0000_0000, ready: 1'b1,
				alarm_n: 1'b1, resp: '0};
			hresp_reg <= 1'b0;
		end else begin
			st <= nx;
			hresp_reg <= 1'b0;
		end
	end

	assign hrdata = st.rdata;
	assign hreadyout = st.ready;
	assign hresp = hresp_reg;
	assign resp_out = st.resp;
	assign alarm_out_n = st.alarm_n;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	mask_blocks_sum_a: assert property (
		st.mask1[`M1_PROT] && $past(st.mask1[`M1_PROT]) |-> !st.summary[`S_PROT])
		else $error("masked group reached summary");

	pin_follows_sum_a: assert property (
		st.summary == 8'h00 && !(st.cfg[`CFG_BASE] && st.vote) |-> alarm_out_n)
		else $error("alarm pin low without unmasked fault");

	pin_disabled_a: assert property (
		!st.cfg[`CFG_PIN_EN] |-> alarm_out_n)
		else $error("alarm pin low while disabled");

	flag_latched_a: assert property (
		st.flags[`F_PROT][0] && !clr1[`M1_PROT] |=> st.flags[`F_PROT][0])
		else $error("flag lost without clear");

	clear_works_a: assert property (
		clr1[`M1_UV] && !fault_set[`F_UV][0] && !fault_active[`F_UV][0]
		|=> !st.flags[`F_UV][0])
		else $error("group clear left flag set");

	clear_held_a: assert property (
		st.flags[`F_OV][1] && clr1[`M1_OV] && fault_active[`F_OV][1] |=> st.flags[`F_OV][1])
		else $error("clear removed live condition");

	set_flag_a: assert property (
		fault_set[`F_SYS][2] && !st.mask1[`M1_SYS] && !(st.phase == fault_pkg::BUS_WR)
		|=> st.flags[`F_SYS][2] && st.summary[`S_SYS])
		else $error("fault not latched into flag and summary");

	sum_needs_flags_a: assert property (
		st.summary[`S_OTUT] |-> (|st.flags[`F_OT]) || (|st.flags[`F_UT]))
		else $error("summary set with empty group");

	embed_or_a: assert property (
		st.cfg[`CFG_EMBED_EN] && resp_in.valid && |st.summary
		|=> resp_out.valid && resp_out.status == 3'b111)
		else $error("fault state not embedded");

	vote_sets_det_a: assert property (
		vote_now |=> st.flags[`F_TONE][`B_CHAIN_DET])
		else $error("chain vote did not latch detect flag");

	base_vote_pin_a: assert property (
		vote_now && st.cfg[`CFG_BASE] && st.cfg[`CFG_PIN_EN] && !cfg_wr |=> !alarm_out_n)
		else $error("base ignored chain vote");

	read_wait_a: assert property (
		st.ready && hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	otut_pair_a: assert property (
		st.mask1[`M1_OT] && st.mask1[`M1_UT] |-> !st.summary[`S_OTUT])
		else $error("masked temperature pair reached summary");

	ovuv_pair_a: assert property (
		st.mask1[`M1_OV] && st.mask1[`M1_UV] |-> !st.summary[`S_OVUV])
		else $error("masked voltage pair reached summary");

	mask_write_a: assert property (
		st.phase == fault_pkg::BUS_WR && st.addr == `OFS_MASK1
		|=> st.mask1 == $past(hwdata[7:0]))
		else $error("first mask write lost");

	comm_masked_a: assert property (
		st.mask2[`M2_COMM1] && st.mask2[`M2_COMM2] && st.mask2[`M2_HB] &&
		st.mask2[`M2_TONE] && st.mask2[`M2_CHAIN] |-> !st.summary[`S_COMM])
		else $error("masked link groups reached summary");

	nvm_masked_a: assert property (
		st.mask2[`M2_NVM_CRC] && st.mask2[`M2_NVM_DATA] |-> !st.summary[`S_NVM])
		else $error("masked memory group reached summary");

	crc_clear_a: assert property (
		clr2[`M2_NVM_CRC] && !fault_set[`F_NVM][0] && !fault_active[`F_NVM][0]
		|=> !st.flags[`F_NVM][0])
		else $error("second clear register bit layout wrong");

	detail_clear_a: assert property (
		clr2[`M2_COMM1] && !detail_load[0] |=> st.detail[0] == 8'h00)
		else $error("group clear left detail register set");

	block_load_a: assert property (
		detail_load[`D_NVM_SEC] |=> st.detail[`D_NVM_SEC] == $past(detail_value[`D_NVM_SEC]))
		else $error("block location not loaded");

	detail_sticky_a: assert property (
		detail_load[2] |=> (st.detail[2] & $past(detail_value[2])) == $past(detail_value[2]))
		else $error("detail bits not accumulated");

	set_wins_a: assert property (
		fault_set[`F_COMP][5] |=> st.flags[`F_COMP][5])
		else $error("fault event not latched");

	masked_sets_a: assert property (
		fault_set[`F_PWR][3] && st.mask1[`M1_PWR] |=> st.flags[`F_PWR][3])
		else $error("masked group lost its flag");

	top_empty_a: assert property (
		st.flags == '0 && st.detail == '0 |-> st.summary == 8'h00)
		else $error("summary set with no low-level flag");

	pin_any_sum_a: assert property (
		st.cfg[`CFG_PIN_EN] && st.summary != 8'h00 |-> !alarm_out_n)
		else $error("alarm pin high with summary set");

	base_chain_a: assert property (
		st.cfg[`CFG_PIN_EN] && st.cfg[`CFG_BASE] && st.vote |-> !alarm_out_n)
		else $error("base pin ignored chain fault");

	embed_off_a: assert property (
		!st.cfg[`CFG_EMBED_EN] && resp_in.valid |=> resp_out.status == $past(resp_in.status))
		else $error("header changed with embedding off");

	no_fault_pass_a: assert property (
		resp_in.valid && st.summary == 8'h00 |=> resp_out.status == $past(resp_in.status))
		else $error("fault-free device changed header");

	det_flag_sum_a: assert property (
		st.flags[`F_TONE][`B_CHAIN_DET] && !st.mask2[`M2_CHAIN] |-> st.summary[`S_COMM])
		else $error("chain detect flag missing from summary");

	persist_clear_c: cover property (clr1[`M1_OV] && fault_active[`F_OV] != 8'h00);
	base_alarm_c: cover property (vote_now && st.cfg[`CFG_BASE] ##1 !alarm_out_n);
	masked_event_c: cover property (fault_set[`F_PROT] != 8'h00 && st.mask1[`M1_PROT]);
	embed_fwd_c: cover property (resp_out.valid && resp_out.status == 3'b111);
	chain_det_c: cover property (st.flags[`F_TONE][`B_CHAIN_DET] && !alarm_out_n);

endmodule
`default_nettype wire

/* File: tb/chain_partner.sv */
// Upstream chain neighbour forwarding one response frame per request.
// Assumes requests arrive as one-cycle pulses on hclk.
`timescale 1ns/1ps
`default_nettype none

module chain_partner (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic [2:0] hdr,
	input wire logic up_fault,
	output fault_pkg::frame_t frame
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame <= '0;
		end else begin
			frame.valid <= go;
			// Own state ORed in as all zeros or all ones
			// Idle header toggles so a stale value never looks fresh
			frame.status <= go ? (hdr | {3{up_fault}}) : ~frame.status;
		end
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the fault aggregation block.
// Assumes the register map and bit layout of fault_cfg.svh.
`timescale 1ns/1ps
`default_nettype none
`include "fault_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end

module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	fault_pkg::flag_bank_t fault_set = '0;
	fault_pkg::flag_bank_t fault_active = '0;
	logic [9:0] detail_load = '0;
	fault_pkg::detail_bank_t detail_value = '0;
	fault_pkg::frame_t resp_in;
	fault_pkg::frame_t resp_out;
	logic alarm_out_n;
	logic go = 1'b0;
	logic [2:0] hdr = 3'b000;
	logic up_fault = 1'b0;
	logic [2:0] got_status = 3'b000;
	logic [31:0] rdat;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int frames = 0;
	typedef struct {int fi; int fb; int co; int cb; int sb;} row_t;
	row_t rows[14] = '{
		'{`F_PROT, 0, `OFS_CLR1, `M1_PROT, `S_PROT}, '{`F_UT, 2, `OFS_CLR1, `M1_UT, `S_OTUT},
		'{`F_OT, 1, `OFS_CLR1, `M1_OT, `S_OTUT}, '{`F_UV, 3, `OFS_CLR1, `M1_UV, `S_OVUV},
		'{`F_OV, 7, `OFS_CLR1, `M1_OV, `S_OVUV}, '{`F_COMP, 4, `OFS_CLR1, `M1_COMP, `S_COMP},
		'{`F_SYS, 5, `OFS_CLR1, `M1_SYS, `S_SYS}, '{`F_PWR, 6, `OFS_CLR1, `M1_PWR, `S_PWR},
		'{`F_NVM, 0, `OFS_CLR2, `M2_NVM_CRC, `S_NVM}, '{`F_NVM, 3, `OFS_CLR2, `M2_NVM_DATA, `S_NVM},
		'{`F_HOST, 1, `OFS_CLR2, `M2_COMM1, `S_COMM}, '{`F_CHAIN, 4, `OFS_CLR2, `M2_COMM2, `S_COMM},
		'{`F_TONE, 1, `OFS_CLR2, `M2_TONE, `S_COMM}, '{`F_TONE, 2, `OFS_CLR2, `M2_HB, `S_COMM}};

	fault_mask_clear_signaling fault_mask_clear_signaling_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .fault_set(fault_set), .fault_active(fault_active),
		.detail_load(detail_load), .detail_value(detail_value), .resp_in(resp_in),
		.resp_out(resp_out), .alarm_out_n(alarm_out_n));
	chain_partner chain_partner_inst (.hclk(hclk), .hresetn(hresetn), .go(go), .hdr(hdr),
		.up_fault(up_fault), .frame(resp_in));

	always #50 hclk = ~hclk;

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (resp_out.valid === 1'b1) begin
			got_status <= resp_out.status;
			frames <= frames + 1;
		end
		if (cycles == 6000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic bus(input int a, input logic w, input int d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= 32'(d);
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rdat = hrdata;
	endtask

	task automatic wr(input int a, input int d);
		bus(a, 1'b1, d);
	endtask

	task automatic chk_rd(input int a, input logic [31:0] e);
		bus(a, 1'b0, 0);
		`CHK("register", e, rdat)
	endtask

	task automatic pulse(input int i, input int b);
		@(posedge hclk);
		fault_set[i][b] <= 1'b1;
		@(posedge hclk);
		fault_set <= '0;
	endtask

	task automatic dload(input int i, input logic [7:0] v);
		@(posedge hclk);
		detail_value[i] <= v;
		detail_load[i] <= 1'b1;
		@(posedge hclk);
		detail_load <= '0;
	endtask

	task automatic send(input logic [2:0] h, input logic f, input logic [2:0] e, input logic a);
		int n;
		n = frames;
		@(posedge hclk);
		go <= 1'b1;
		hdr <= h;
		up_fault <= f;
		@(posedge hclk);
		go <= 1'b0;
		repeat (3) @(posedge hclk);
		`CHK("frames", n + 1, frames)
		`CHK("forwarded", e, got_status)
		`CHK("alarm", a, alarm_out_n)
	endtask

	task automatic reset_chk();
		`CHK("alarm", 1'b1, alarm_out_n)
		`CHK("resp", 4'h0, resp_out)
		chk_rd(`OFS_MASK1, 32'(`RST_MASK1));
		chk_rd(`OFS_MASK2, 32'(`RST_MASK2));
		chk_rd(`OFS_CFG, 32'(`RST_CFG));
		chk_rd(`OFS_SUMMARY, 32'h0);
		chk_rd(`OFS_FLAG0 + 4 * `F_SYS, 32'h0);
		chk_rd(`OFS_CLR1, 32'h0);
		chk_rd(8'hfc, 32'h0);
		`CHK("hresp", 1'b0, hresp)
	endtask

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		reset_chk();
		foreach (rows[i]) begin
			pulse(rows[i].fi, rows[i].fb);
			chk_rd(`OFS_SUMMARY, 32'(1 << rows[i].sb));
			chk_rd(`OFS_FLAG0 + 4 * rows[i].fi, 32'(1 << rows[i].fb));
			`CHK("alarm", 1'b1, alarm_out_n)
			wr(rows[i].co ^ 4, 1 << rows[i].cb);
			chk_rd(`OFS_FLAG0 + 4 * rows[i].fi, 32'(1 << rows[i].fb));
			wr(rows[i].co, 1 << rows[i].cb);
			chk_rd(`OFS_FLAG0 + 4 * rows[i].fi, 32'h0);
			chk_rd(`OFS_SUMMARY, 32'h0);
		end
		wr(`OFS_CFG, 1 << `CFG_PIN_EN);
		wr(`OFS_MASK1, (1 << `M1_OT) | (1 << `M1_UT));
		pulse(`F_OT, 0);
		chk_rd(`OFS_FLAG0 + 4 * `F_OT, 32'h1);
		chk_rd(`OFS_SUMMARY, 32'h0);
		`CHK("alarm", 1'b1, alarm_out_n)
		wr(`OFS_MASK1, 1 << `M1_UT);
		chk_rd(`OFS_SUMMARY, 32'(1 << `S_OTUT));
		`CHK("alarm", 1'b0, alarm_out_n)
		wr(`OFS_MASK1, 0);
		fault_active[`F_UT][1] <= 1'b1;
		pulse(`F_UT, 1);
		wr(`OFS_CLR1, (1 << `M1_OT) | (1 << `M1_UT));
		chk_rd(`OFS_FLAG0 + 4 * `F_UT, 32'h2);
		chk_rd(`OFS_FLAG0 + 4 * `F_OT, 32'h0);
		chk_rd(`OFS_SUMMARY, 32'(1 << `S_OTUT));
		fault_active <= '0;
		repeat (4) @(posedge hclk);
		chk_rd(`OFS_FLAG0 + 4 * `F_UT, 32'h2);
		wr(`OFS_CLR1, 1 << `M1_UT);
		chk_rd(`OFS_SUMMARY, 32'h0);
		`CHK("alarm", 1'b1, alarm_out_n)
		dload(0, 8'h05);
		dload(0, 8'h30);
		dload(8, 8'h12);
		dload(8, 8'h07);
		chk_rd(`OFS_DETAIL0, 32'h35);
		chk_rd(`OFS_DETAIL0 + 4 * `D_NVM_SEC, 32'h07);
		wr(`OFS_CLR2, 1 << `M2_COMM1);
		chk_rd(`OFS_DETAIL0, 32'h0);
		wr(`OFS_CLR2, 1 << `M2_NVM_DATA);
		chk_rd(`OFS_DETAIL0 + 4 * `D_NVM_SEC, 32'h0);
		wr(`OFS_CFG, 7);
		send(3'b000, 1'b0, 3'b000, 1'b1);
		send(3'b001, 1'b0, 3'b001, 1'b1);
		send(3'b100, 1'b0, 3'b100, 1'b1);
		send(3'b110, 1'b0, 3'b110, 1'b0);
		chk_rd(`OFS_SUMMARY, 32'(1 << `S_COMM));
		chk_rd(`OFS_FLAG0 + 4 * `F_TONE, 32'(1 << `B_CHAIN_DET));
		send(3'b000, 1'b0, 3'b111, 1'b0);
		wr(`OFS_MASK2, 1 << `M2_CHAIN);
		chk_rd(`OFS_SUMMARY, 32'h0);
		send(3'b000, 1'b0, 3'b000, 1'b1);
		send(3'b000, 1'b1, 3'b111, 1'b0);
		wr(`OFS_CLR2, 1 << `M2_CHAIN);
		wr(`OFS_MASK2, 0);
		wr(`OFS_CFG, 1 << `CFG_BASE);
		send(3'b101, 1'b0, 3'b101, 1'b1);
		chk_rd(`OFS_FLAG0 + 4 * `F_TONE, 32'h0);
		wr(`OFS_MASK1, 8'hff);
		pulse(`F_SYS, 0);
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		reset_chk();
		close_out();
	end
endmodule
`default_nettype wire
